// ---- design/power_ctl_pkg.sv ----
// Operation
// - Standby and full-function states chosen by a host-written control bit.
// - Host changes modes over the serial link; device answers setup queries.
// - In standby the parallel video output link is not driven.
// - In standby the sensor ignores exposure and readout control.
// - In standby the monitor video output is not driven.
// - Working configuration is kept unchanged through standby.
// - Serial command link stays fully working during standby.
// - Full function is reached at most 0.5 s after leaving standby.
// - Power-up from unpowered completes within at most 3 s.
// - During boot the indicator shows orange, sometimes alternating with green.
// - After a clean boot the indicator stays steadily orange.
// - An error after boot makes the indicator flash an error code (errors are taken only in run, not in standby or wake).
package power_ctl_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int WAKE_MS = 500;
	localparam int BOOT_MS = 3000;
	localparam int WAKE_CYC = CLK_HZ / 1000 * WAKE_MS;
	localparam int BOOT_CYC = CLK_HZ / 1000 * BOOT_MS;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	localparam int ERR_W = 4;

	typedef enum logic [4:0] {
		ST_BOOT = 5'h01,
		ST_RUN = 5'h02,
		ST_STANDBY = 5'h04,
		ST_WAKE = 5'h08,
		ST_ERROR = 5'h10
	} pwr_state_t;

	typedef enum logic [1:0] {
		LED_OFF = 2'h0,
		LED_ORANGE = 2'h1,
		LED_GREEN = 2'h2
	} led_color_t;

	typedef struct packed {
		logic video_en;
		logic sensor_en;
		logic monitor_en;
		logic ready;
	} pwr_enables_t;
endpackage : power_ctl_pkg

// ---- design/standby_power_status_control.sv ----
`timescale 1ns/100ps
module standby_power_status_control import power_ctl_pkg::*; #(
	parameter int WAKE_CYCLES = WAKE_CYC,
	parameter int BOOT_CYCLES = BOOT_CYC,
	parameter int BLINK_CYCLES = BLINK_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Supply and control
	input wire logic supply_ok_i,
	input wire logic standby_sel_i,
	input wire logic boot_done_i,
	input wire logic error_i,
	input wire logic [ERR_W-1:0] error_code_i,
	// Trigger
	input wire logic external_frame_trigger_i,
	// Outputs
	output pwr_enables_t enables_o,
	output logic frame_start_o,
	output led_color_t led_o
);

	////////////////////////////////////////////////////////////////////////
	pwr_state_t state_r, state_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic trig_r, trig_nxt;
	logic [ERR_W-1:0] err_r, err_nxt;

	// Serial link and configuration live outside this block and are never gated.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		err_nxt = err_r;
		trig_nxt = external_frame_trigger_i;
		case (state_r)
			ST_BOOT: begin
				// Bounded: forced to run at the limit even if the processor is late
				if (boot_done_i || cnt_r >= 32'(BOOT_CYCLES - 1)) begin
					state_nxt = ST_RUN;
					cnt_nxt = '0;
				end else begin
					cnt_nxt = cnt_r + 32'h1;
				end
			end
			ST_RUN: begin
				if (error_i) begin
					state_nxt = ST_ERROR;
					err_nxt = error_code_i;
					cnt_nxt = '0;
				end else if (standby_sel_i) begin
					state_nxt = ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (!standby_sel_i) begin
					state_nxt = ST_WAKE;
					cnt_nxt = '0;
				end
			end
			ST_WAKE: begin
				if (standby_sel_i) begin
					state_nxt = ST_STANDBY;
				end else if (cnt_r >= 32'(WAKE_CYCLES - 1)) begin
					state_nxt = ST_RUN;
					cnt_nxt = '0;
				end else begin
					cnt_nxt = cnt_r + 32'h1;
				end
			end
			ST_ERROR: begin
				// Error is sticky until power cycles; blink phase counter
				cnt_nxt = cnt_r + 32'h1;
			end
			default: begin
				state_nxt = ST_BOOT;
				cnt_nxt = '0;
			end
		endcase
		if (!supply_ok_i) begin
			state_nxt = ST_BOOT;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_BOOT;
			cnt_r <= '0;
			trig_r <= 1'b0;
			err_r <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			trig_r <= trig_nxt;
			err_r <= err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Error and run both keep video alive; only standby/wake/boot gate it
	logic active, sensor_ok;
	assign active = (state_r == ST_RUN) || (state_r == ST_ERROR);
	// Triggers during wake are dropped, so the host must not count on them
	assign sensor_ok = active;

	pwr_enables_t en_nxt, en_r;
	logic start_nxt, start_r;
	led_color_t led_nxt, led_r;
	logic [31:0] blink_idx;

	always_comb begin
		en_nxt.video_en = active && (state_r != ST_STANDBY);
		en_nxt.sensor_en = sensor_ok;
		en_nxt.monitor_en = active;
		// Present power state, read back by the serial query decoder
		en_nxt.ready = active;
		start_nxt = sensor_ok && external_frame_trigger_i && !trig_r;
		blink_idx = cnt_r / 32'(BLINK_CYCLES);
		led_nxt = LED_ORANGE;
		if (!supply_ok_i) begin
			led_nxt = LED_OFF;
		end else if (state_r == ST_BOOT) begin
			// Alternate every blink period while the processor boots
			led_nxt = blink_idx[0] ? LED_GREEN : LED_ORANGE;
		end else if (state_r == ST_ERROR) begin
			// Code is the number of flashes in a window of 2*(2^(ERR_W+1)) periods
			if (blink_idx[0] || (32'(blink_idx[ERR_W+1:1]) >= 32'(err_r))) begin
				led_nxt = LED_OFF;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_r <= '0;
			start_r <= 1'b0;
			led_r <= LED_OFF;
		end else begin
			en_r <= en_nxt;
			start_r <= start_nxt;
			led_r <= led_nxt;
		end
	end

	assign enables_o = en_r;
	assign frame_start_o = start_r;
	assign led_o = led_r;

	////////////////////////////////////////////////////////////////////////
	// Checker-only: length of the current wake interval
	int unsigned wake_len_r, wake_len_nxt;

	always_comb begin
		wake_len_nxt = 0;
		if (state_r == ST_WAKE) begin
			wake_len_nxt = wake_len_r + 1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_len_r <= 0;
		end else begin
			wake_len_r <= wake_len_nxt;
		end
	end

	sequence wake_begin_s;
		state_r == ST_STANDBY && !standby_sel_i && supply_ok_i;
	endsequence

	sequence standby_entry_s;
		state_r == ST_RUN && standby_sel_i && !error_i && supply_ok_i;
	endsequence

	// Standby is entered first, the outputs drop one edge later
	sequence enables_off_s;
		state_r == ST_STANDBY ##1 !enables_o.ready;
	endsequence

	standby_entry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		standby_entry_s |=> enables_off_s)
		else $error("standby not entered");
	run_enables_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_RUN |=> enables_o.video_en && enables_o.sensor_en
			&& enables_o.monitor_en)
		else $error("run outputs not enabled");
	boot_exit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_BOOT && boot_done_i && supply_ok_i |=> state_r == ST_RUN)
		else $error("boot did not finish");
	boot_led_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_BOOT && supply_ok_i |=> led_o != LED_OFF)
		else $error("boot led dark");
	error_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_ERROR && supply_ok_i |=> state_r == ST_ERROR)
		else $error("error state left");
	wake_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_WAKE |=> !frame_start_o && !enables_o.sensor_en)
		else $error("sensor active during wake");

	standby_video_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_STANDBY |=> !enables_o.video_en)
		else $error("video driven in standby");
	standby_sensor_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_STANDBY |=> !enables_o.sensor_en && !frame_start_o)
		else $error("sensor active in standby");
	standby_monitor_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_STANDBY |=> !enables_o.monitor_en)
		else $error("monitor driven in standby");
	wake_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wake_begin_s |=> state_r == ST_WAKE)
		else $error("wake not started");
	wake_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wake_len_r <= WAKE_CYCLES)
		else $error("wake too long");
	boot_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_BOOT |-> cnt_r < 32'(BOOT_CYCLES))
		else $error("boot too long");
	led_dark_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!supply_ok_i |=> led_o == LED_OFF)
		else $error("led lit without supply");
	run_orange_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_RUN && supply_ok_i |=> led_o == LED_ORANGE)
		else $error("run not orange");
	error_enter_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_r == ST_RUN && error_i && supply_ok_i |=> state_r == ST_ERROR)
		else $error("error not latched");
	trig_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		frame_start_o |-> $past(external_frame_trigger_i) && !$past(trig_r)
			&& $past(sensor_ok))
		else $error("frame start without trigger");

endmodule : standby_power_status_control

// ---- test/frame_grabber_model.sv ----
`timescale 1ns/100ps
module frame_grabber_model (
	// Clock
	input wire logic clk_i,
	// Toward the camera
	output logic standby_sel_o,
	output logic trigger_o
);
	initial begin
		standby_sel_o = 1'b0;
		trigger_o = 1'b0;
	end
	// Decoded mode command lands as a level
	task automatic command(input logic standby);
		@(posedge clk_i);
		#1 standby_sel_o = standby;
	endtask : command
	// Held two cycles so the rising edge is surely seen
	task automatic fire();
		@(posedge clk_i);
		#1 trigger_o = 1'b1;
		repeat (2) @(posedge clk_i);
		#1 trigger_o = 1'b0;
	endtask : fire
endmodule : frame_grabber_model

// ---- test/standby_power_status_control_tb.sv ----
`timescale 1ns/100ps
module standby_power_status_control_tb import power_ctl_pkg::*;;
	localparam int WK = 20;
	localparam int BL = 4;
	logic clk_i = 0, rst_n_i = 0, supply_ok_i = 1, boot_done_i = 0, error_i = 0;
	logic [ERR_W-1:0] error_code_i = '0;
	logic standby_sel_i, external_frame_trigger_i, frame_start_o;
	pwr_enables_t enables_o;
	led_color_t led_o;
	int n_errors = 0, n_checks = 0, n, orn, off, grn;
	initial forever #5 clk_i = ~clk_i;
	frame_grabber_model grabber (.clk_i(clk_i), .standby_sel_o(standby_sel_i),
		.trigger_o(external_frame_trigger_i));
	standby_power_status_control #(.WAKE_CYCLES(WK), .BOOT_CYCLES(50), .BLINK_CYCLES(BL)) uut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .supply_ok_i(supply_ok_i),
		.standby_sel_i(standby_sel_i), .boot_done_i(boot_done_i), .error_i(error_i),
		.error_code_i(error_code_i), .external_frame_trigger_i(external_frame_trigger_i),
		.enables_o(enables_o), .frame_start_o(frame_start_o), .led_o(led_o));
	function automatic logic [3:0] en_exp(input logic act);
		return act ? 4'hf : 4'h0;
	endfunction : en_exp
	// Orange cycles in one full flash window: one period per code step
	function automatic int flash_exp(input logic [ERR_W-1:0] code);
		return BL * int'(code);
	endfunction : flash_exp
	task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask : check
	task automatic wait_en(input logic act, input int lim);
		for (int i = 0; i < lim && enables_o !== en_exp(act); i++) begin
			@(posedge clk_i);
			#2;
		end
	endtask : wait_en
	task automatic trig(output int cnt);
		cnt = 0;
		fork
			grabber.fire();
			repeat (5) begin
				@(posedge clk_i);
				#2 cnt += int'(frame_start_o === 1'b1);
			end
		join
	endtask : trig
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	initial begin
		#100us;
		n_errors++;
		test_done();
	end
	initial begin
		void'($urandom(32'h96b4bb1a));
		repeat (2) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		orn = 0;
		grn = 0;
		repeat (8) begin
			@(posedge clk_i);
			#2 orn += int'(led_o === LED_ORANGE);
			grn += int'(led_o === LED_GREEN);
		end
		check(enables_o, en_exp(0), "boot enables");
		check(4'(orn > 0 && grn > 0), 4'h1, "boot led");
		trig(n);
		check(4'(n), 4'h0, "boot trigger");
		@(posedge clk_i);
		#1 boot_done_i = 1'b1;
		wait_en(1, 60);
		check(enables_o, en_exp(1), "run enables");
		check(4'(led_o), 4'(LED_ORANGE), "run led");
		for (int k = 0; k < 4; k++) begin
			trig(n);
			check(4'(n), 4'h1, "run trigger");
			grabber.command(1'b1);
			wait_en(0, 5);
			check(enables_o, en_exp(0), "standby enables");
			trig(n);
			check(4'(n), 4'h0, "standby trigger");
			repeat ($urandom_range(1, 30)) @(posedge clk_i);
			grabber.command(1'b0);
			trig(n);
			check(4'(n), 4'h0, "wake trigger");
			check(enables_o, en_exp(0), "wake early");
			wait_en(1, WK + 5);
			check(enables_o, en_exp(1), "wake done");
		end
		@(posedge clk_i);
		#1 error_code_i = ERR_W'($urandom_range(1, 15));
		error_i = 1'b1;
		orn = 0;
		off = 0;
		// First sample still shows run; then the first half of a flash window is counted
		for (int i = 0; i < 200; i++) begin
			@(posedge clk_i);
			#2 off += int'(led_o === LED_OFF);
			if (i >= 1 && i <= (2 ** (ERR_W + 1)) * BL) orn += int'(led_o === LED_ORANGE);
		end
		check(4'(off > 0), 4'h1, "error blink");
		check(4'(orn == flash_exp(error_code_i)), 4'h1, "error code");
		@(posedge clk_i);
		#1 supply_ok_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#2 check(4'(led_o), 4'(LED_OFF), "no supply led");
		test_done();
	end
endmodule : standby_power_status_control_tb
